// [design/epl_pkg.sv]
// Purpose: constants for the power-management capability loader
// Assumes: config word is 16 bits, registers are 32 bits
// Notes: field positions, widths and reset defaults, no timing
package epl_pkg;
  localparam int CFG_W = 16;
  localparam int REG_W = 32;
  // config word fields
  localparam int CFG_VER_LO = 0;
  localparam int CFG_VER_HI = 2;
  localparam int CFG_CLK_BIT = 3;
  localparam int CFG_DSI_BIT = 5;
  localparam int CFG_D1_BIT = 9;
  // capability register fields
  localparam int PMC_VER_LO = 0;
  localparam int PMC_VER_HI = 2;
  localparam int PMC_CLK_BIT = 3;
  localparam int PMC_DSI_BIT = 5;
  localparam int PMC_D1_BIT = 9;
  // capability-id register fields
  localparam int CID_VER_LO = 16;
  localparam int CID_VER_HI = 18;
  localparam int CID_CLK_BIT = 19;
  localparam int CID_DSI_BIT = 21;
  localparam int CID_D1_BIT = 25;
  // reset defaults, used when no eeprom answers
  localparam logic [31:0] PMC_RESET = 32'h0000_0002;
  localparam logic [31:0] CID_RESET = 32'h0002_0001;
endpackage

// [design/epl_loader.sv]
// Purpose: copy eeprom power-management fields into capability registers
// Assumes: cfg_valid pulses once the eeprom word has been read
// Notes: loads once per reset; defaults kept with no eeprom
`timescale 1ns/1ps
module epl_loader
  import epl_pkg::*;
(
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // sync reset, high
  input wire logic eeprom_present, // eeprom detected
  input wire logic cfg_valid, // config word valid pulse
  input wire logic [CFG_W-1:0] eeprom_config_word, // word from eeprom
  output logic [REG_W-1:0] power_mgmt_capability_reg, // capability reg
  output logic [REG_W-1:0] capability_id_config_reg, // capability-id reg
  output logic load_done, // copy finished, config space readable
  output logic dsi_required, // special init needed
  output logic wake_event_clock_needed // wake event needs pci clock
);

  // ****************************************************
  // load control
  // ****************************************************
  logic loaded_reg;
  logic take;
  // only the first word after reset is taken; later pulses are ignored
  assign take = cfg_valid && eeprom_present && !loaded_reg;

  // done flag; without eeprom the defaults stand and done rises at once
  always_ff @(posedge clk)
  begin
    if (rst)
      loaded_reg <= 1'b0;
    else if (take || !eeprom_present)
      loaded_reg <= 1'b1;
  end
  assign load_done = loaded_reg;

  // ****************************************************
  // field copies
  // ****************************************************
  logic [REG_W-1:0] pmc_next;
  logic [REG_W-1:0] cid_next;

  // width of the version field, shared by the word and both registers
  localparam int VER_W = CFG_VER_HI - CFG_VER_LO + 1;

  // one routine lays the loaded fields over a register image; both
  // registers share it so the word-side bit map lives in one place
  function automatic logic [REG_W-1:0] place_fields(
    input logic [REG_W-1:0] base, // register image before the load
    input logic [CFG_W-1:0] word, // word from the eeprom
    input int ver_lo, // lowest version bit in the register
    input int clk_bit, // clock-flag bit in the register
    input int dsi_bit, // init-flag bit in the register
    input int d1_bit // D1-flag bit in the register
  );
    logic [REG_W-1:0] img;
    img = base;
    img[dsi_bit] = word[CFG_DSI_BIT];
    img[clk_bit] = word[CFG_CLK_BIT];
    img[ver_lo +: VER_W] = word[CFG_VER_LO +: VER_W];
    img[d1_bit] = word[CFG_D1_BIT];
    return img;
  endfunction

  // both images start from the live registers, so bits outside the
  // loaded fields keep their reset defaults through the load
  always_comb
  begin
    pmc_next = place_fields(power_mgmt_capability_reg, eeprom_config_word,
      PMC_VER_LO, PMC_CLK_BIT, PMC_DSI_BIT, PMC_D1_BIT);
    cid_next = place_fields(capability_id_config_reg, eeprom_config_word,
      CID_VER_LO, CID_CLK_BIT, CID_DSI_BIT, CID_D1_BIT);
  end

  // registers hold defaults until the one load
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      power_mgmt_capability_reg <= PMC_RESET;
      capability_id_config_reg <= CID_RESET;
    end
    else if (take)
    begin
      power_mgmt_capability_reg <= pmc_next;
      capability_id_config_reg <= cid_next;
    end
  end

  // advertised capability levels follow the loaded bits
  assign dsi_required = power_mgmt_capability_reg[PMC_DSI_BIT];
  assign wake_event_clock_needed =
    power_mgmt_capability_reg[PMC_CLK_BIT];

  // ****************************************************
  // checks
  // ****************************************************
  // a load has two steps: the word is taken, then the copies stand
  sequence s_take;
    take;
  endsequence

  sequence s_loaded;
    load_done;
  endsequence

  // bits a load may change; the keep check needs the complement
  function automatic logic [REG_W-1:0] field_mask(
    input int ver_lo, // lowest version bit
    input int clk_bit, // clock-flag bit
    input int dsi_bit, // init-flag bit
    input int d1_bit // D1-flag bit
  );
    logic [REG_W-1:0] m;
    m = '0;
    m[ver_lo +: VER_W] = '1;
    m[clk_bit] = 1'b1;
    m[dsi_bit] = 1'b1;
    m[d1_bit] = 1'b1;
    return m;
  endfunction

  // init flag lands in both registers and on the status level
  property p_dsi;
    @(posedge clk) disable iff (rst)
    s_take |=> power_mgmt_capability_reg[PMC_DSI_BIT] ==
      $past(eeprom_config_word[CFG_DSI_BIT]) &&
      capability_id_config_reg[CID_DSI_BIT] ==
      $past(eeprom_config_word[CFG_DSI_BIT]) &&
      dsi_required == $past(eeprom_config_word[CFG_DSI_BIT]);
  endproperty
  a_dsi: assert property (p_dsi)
    else $error("init flag not copied");

  // clock flag lands in both registers and on the advertised level
  property p_clk;
    @(posedge clk) disable iff (rst)
    s_take |=> power_mgmt_capability_reg[PMC_CLK_BIT] ==
      $past(eeprom_config_word[CFG_CLK_BIT]) &&
      capability_id_config_reg[CID_CLK_BIT] ==
      $past(eeprom_config_word[CFG_CLK_BIT]) &&
      wake_event_clock_needed == $past(eeprom_config_word[CFG_CLK_BIT]);
  endproperty
  a_clk: assert property (p_clk)
    else $error("clock flag not copied");

  // version field lands in both registers
  property p_ver;
    @(posedge clk) disable iff (rst)
    s_take |=> capability_id_config_reg[CID_VER_HI:CID_VER_LO] ==
      $past(eeprom_config_word[CFG_VER_HI:CFG_VER_LO]) &&
      power_mgmt_capability_reg[PMC_VER_HI:PMC_VER_LO] ==
      $past(eeprom_config_word[CFG_VER_HI:CFG_VER_LO]);
  endproperty
  a_ver: assert property (p_ver)
    else $error("version not copied");

  // D1 flag checked against the word, not only between the registers
  property p_d1;
    @(posedge clk) disable iff (rst)
    s_take |=> power_mgmt_capability_reg[PMC_D1_BIT] ==
      $past(eeprom_config_word[CFG_D1_BIT]) &&
      capability_id_config_reg[CID_D1_BIT] ==
      $past(eeprom_config_word[CFG_D1_BIT]);
  endproperty
  a_d1: assert property (p_d1)
    else $error("d1 flag not copied");

  // once loaded, nothing but a reset may touch the registers
  property p_hold;
    @(posedge clk) disable iff (rst)
    loaded_reg |=> $stable(power_mgmt_capability_reg) &&
      $stable(capability_id_config_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("reload after done");

  // with no eeprom the defaults stand
  property p_dflt;
    @(posedge clk) disable iff (rst)
    !eeprom_present && !loaded_reg |-> power_mgmt_capability_reg == PMC_RESET &&
      capability_id_config_reg == CID_RESET;
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("defaults lost");

  // done follows a taken word by one cycle
  property p_done;
    @(posedge clk) disable iff (rst)
    s_take |=> s_loaded;
  endproperty
  a_done: assert property (p_done)
    else $error("done missing after load");

  // without an eeprom the host is not kept waiting
  property p_nopres;
    @(posedge clk) disable iff (rst)
    !eeprom_present |=> load_done;
  endproperty
  a_nopres: assert property (p_nopres)
    else $error("done missing without eeprom");

  // before the load both registers show their defaults
  property p_pre;
    @(posedge clk) disable iff (rst)
    !loaded_reg |-> power_mgmt_capability_reg == PMC_RESET &&
      capability_id_config_reg == CID_RESET;
  endproperty
  a_pre: assert property (p_pre)
    else $error("registers changed before load");

  // a word offered with no eeprom present is refused
  property p_refuse;
    @(posedge clk) disable iff (rst)
    !eeprom_present && cfg_valid |=> $stable(power_mgmt_capability_reg) &&
      $stable(capability_id_config_reg);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("word taken without eeprom");

  // a load leaves every bit outside the four fields at its default
  property p_keep;
    @(posedge clk) disable iff (rst)
    s_take |=> ((power_mgmt_capability_reg ^ PMC_RESET) &
      ~field_mask(PMC_VER_LO, PMC_CLK_BIT, PMC_DSI_BIT, PMC_D1_BIT)) ==
      REG_W'(0) &&
      ((capability_id_config_reg ^ CID_RESET) &
      ~field_mask(CID_VER_LO, CID_CLK_BIT, CID_DSI_BIT, CID_D1_BIT)) ==
      REG_W'(0);
  endproperty
  a_keep: assert property (p_keep)
    else $error("bits outside the fields changed");
endmodule

// [verif/epl_eeprom_model.sv]
// Purpose: eeprom stand-in handing over one config word
// Assumes: word and valid last one clock
// Notes: idle data lines invert their value on every clock
`timescale 1ns/1ps
module epl_eeprom_model
  import epl_pkg::*;
(
  input wire logic clk, // bench clock
  input wire logic send, // request one word
  input wire logic [CFG_W-1:0] word_in, // word to hand over
  output logic cfg_valid, // one-cycle valid
  output logic [CFG_W-1:0] eeprom_config_word // data lines
);
  // idle data inverted so a stale word never looks valid
  always @(posedge clk)
  begin
    cfg_valid <= send;
    eeprom_config_word <= send ? word_in : ~eeprom_config_word;
  end
endmodule

// [verif/test_epl_loader.sv]
// Purpose: self-checking bench for the capability loader
// Assumes: one load per reset
// Notes: later words must be ignored
`timescale 1ns/1ps
module test_epl_loader
  import epl_pkg::*;
;
  logic clk, rst, pres, send, vld, done, dsi, wck;
  logic [CFG_W-1:0] word, cw;
  logic [REG_W-1:0] pmc, cid, ep, ec;
  int fails = 0, compares = 0, seed = 58127;
  // reference: the first accepted word since reset; empty means defaults
  logic [CFG_W-1:0] taken_q[$];
  epl_eeprom_model i_mem(.clk(clk), .send(send), .word_in(word),
    .cfg_valid(vld), .eeprom_config_word(cw));
  epl_loader i_dut(.clk(clk), .rst(rst), .eeprom_present(pres),
    .cfg_valid(vld), .eeprom_config_word(cw),
    .power_mgmt_capability_reg(pmc), .capability_id_config_reg(cid),
    .load_done(done), .dsi_required(dsi), .wake_event_clock_needed(wck));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [REG_W-1:0] g, input logic [REG_W-1:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  // reference image of one register: defaults, then the accepted fields
  function automatic logic [REG_W-1:0] model_reg(
    input logic [REG_W-1:0] dflt, input int ver_lo, input int clk_bit,
    input int dsi_bit, input int d1_bit);
    logic [REG_W-1:0] r;
    logic [CFG_W-1:0] w;
    r = dflt;
    if (taken_q.size() > 0)
    begin
      w = taken_q[0];
      r[dsi_bit] = w[5];
      r[clk_bit] = w[3];
      for (int b = 0; b < 3; b++)
        r[ver_lo + b] = w[b];
      r[d1_bit] = w[9];
    end
    return r;
  endfunction
  // offer one word; the reference keeps it only when it may be taken
  task automatic offer(input logic [CFG_W-1:0] w);
    if (pres && taken_q.size() == 0)
      taken_q.push_back(w);
    send <= 1'b1;
    word <= w;
    @(posedge clk) send <= 1'b0;
  endtask
  // every result against the reference in one place
  task automatic check_all;
    ep = model_reg(PMC_RESET, PMC_VER_LO, PMC_CLK_BIT, PMC_DSI_BIT,
      PMC_D1_BIT);
    ec = model_reg(CID_RESET, CID_VER_LO, CID_CLK_BIT, CID_DSI_BIT,
      CID_D1_BIT);
    cmp(pmc, ep);
    cmp(cid, ec);
    cmp_flag(dsi, ep[5]);
    cmp_flag(wck, ep[3]);
    cmp_flag(done, 1'b1);
  endtask
  task automatic wrap_up;
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one reset, one load when an eeprom is present, then a refused second word
  task automatic run(input logic have);
    logic [CFG_W-1:0] w;
    w = CFG_W'($random(seed));
    // inputs move only on a rising edge
    @(posedge clk);
    rst <= 1'b1;
    pres <= have;
    taken_q.delete();
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    offer(w);
    // valid rises on the edge the offer ends, copies one edge later
    @(posedge clk);
    @(negedge clk);
    check_all();
    @(posedge clk);
    offer(~w);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check_all();
  endtask
  // watchdog well past eight short runs
  initial
  begin
    #20000;
    fails++;
    wrap_up();
  end
  initial
  begin
    {rst, pres, send, word} = {1'b1, 1'b0, 1'b0, 16'h0000};
    for (int i = 0; i < 8; i++) run(i != 1);
    wrap_up();
  end
endmodule
